// [fcw_pkg.sv]
package fcw_pkg;
    // command area byte positions
    localparam int CMD_BYTE_IDX   = 0;
    localparam int COUNT_BYTE_IDX = 1;
    localparam int ADDR_HI_IDX    = 2;
    localparam int ADDR_LO_IDX    = 3;
    localparam int DATA_FIRST_IDX = 4;
    localparam int CMD_AREA_BYTES = 16;
    localparam int MAX_WR_WORDS   = 6;
    localparam int READ_WIN_WORDS = 12;
    // command codes
    localparam logic [7:0] CMD_NONE      = 8'h00;
    localparam logic [7:0] CMD_READ_WIN  = 8'hFA;
    localparam logic [7:0] CMD_REG_WRITE = 8'hFB;
    localparam logic [7:0] CMD_CLR_PRST  = 8'hFC;
    // reset values
    localparam logic [15:0] WIN_START_RST = 16'h0000;
    // analog output block layout
    localparam int AO_CHANNELS    = 4;
    localparam int AO_INT_BYTES   = 4;
    localparam int AO_DEC_BYTES   = 2;
    localparam int AO_INT_STRIDE  = 8;
    localparam int AO_FLT_STRIDE  = 4;
    localparam int AO_BLOCK_BYTES = 16;
    typedef enum logic [1:0] {FCW_IDLE, FCW_WRITE} fcw_state_e;
endpackage

// [fcw_analog_output_channel_pack.sv]
`timescale 1ns/1ps
module fcw_analog_output_channel_pack
    import fcw_pkg::*;
(
    input  wire logic               mclk_i,
    input  wire logic               rst_i,
    input  wire logic [4*32-1:0]    ao_int_i,
    input  wire logic [4*16-1:0]    ao_dec_i,
    input  wire logic [4*32-1:0]    ao_flt_i,
    output logic      [16*8-1:0]    blk_int12_o,
    output logic      [16*8-1:0]    blk_int34_o,
    output logic      [16*8-1:0]    blk_flt_o
);
    logic [16*8-1:0] int12_next;
    logic [16*8-1:0] int34_next;
    logic [16*8-1:0] flt_next;
    logic [16*8-1:0] int12_reg;
    logic [16*8-1:0] int34_reg;
    logic [16*8-1:0] flt_reg;

    // byte 0 sits at the top of each vector, so msb-first order falls out
    always_comb
    begin
        int12_next = '0;
        int34_next = '0;
        flt_next   = '0;
        for (int ch = 0; ch < AO_CHANNELS; ch++)
        begin
            flt_next[(AO_BLOCK_BYTES-AO_FLT_STRIDE*ch)*8-1 -: 32] = ao_flt_i[ch*32 +: 32];
        end
        for (int k = 0; k < 2; k++)
        begin
            // int part, then decimals, then two unused zero bytes
            int12_next[(AO_BLOCK_BYTES-AO_INT_STRIDE*k)*8-1 -: 32] = ao_int_i[k*32 +: 32];
            int12_next[(AO_BLOCK_BYTES-AO_INT_STRIDE*k-AO_INT_BYTES)*8-1 -: 16] =
                ao_dec_i[k*16 +: 16];
            int34_next[(AO_BLOCK_BYTES-AO_INT_STRIDE*k)*8-1 -: 32] = ao_int_i[(k+2)*32 +: 32];
            int34_next[(AO_BLOCK_BYTES-AO_INT_STRIDE*k-AO_INT_BYTES)*8-1 -: 16] =
                ao_dec_i[(k+2)*16 +: 16];
        end
    end

    // register the packed blocks
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            int12_reg <= '0;
            int34_reg <= '0;
            flt_reg   <= '0;
        end
        else
        begin
            int12_reg <= int12_next;
            int34_reg <= int34_next;
            flt_reg   <= flt_next;
        end
    end

    assign blk_int12_o = int12_reg;
    assign blk_int34_o = int34_reg;
    assign blk_flt_o   = flt_reg;
endmodule // fcw_analog_output_channel_pack

// [fcw_command_window.sv]
`timescale 1ns/1ps
// Overview of operation
// - write: count byte, big-endian start address
// - bytes 4-15 are six words, in order
// - float uses two registers, msb first
// - integer value plus decimals register
// - read-window command sets start, twelve registers
// - clear-reset command clears program reset flag
// - other codes execute once per change; a change that arrives while busy_o is high is dropped, not executed later
// - don't-care bytes have no effect
// - integer block: int, decimals, unused bytes
// - outputs 3 and 4 in second block
// - float block: four outputs, four bytes
module fcw_command_window
    import fcw_pkg::*;
(
    input  wire logic               mclk_i,
    input  wire logic               rst_i,
    input  wire logic               upd_i,
    input  wire logic [16*8-1:0]    cmd_area_i,
    input  wire logic [4*32-1:0]    ao_int_i,
    input  wire logic [4*16-1:0]    ao_dec_i,
    input  wire logic [4*32-1:0]    ao_flt_i,
    output logic                    reg_wr_o,
    output logic      [15:0]        reg_wr_addr_o,
    output logic      [15:0]        reg_wr_data_o,
    output logic      [15:0]        win_start_o,
    output logic      [4:0]         win_len_o,
    output logic                    prst_clr_o,
    output logic                    other_cmd_o,
    output logic      [7:0]         other_code_o,
    output logic                    busy_o,
    output logic      [16*8-1:0]    blk_int12_o,
    output logic      [16*8-1:0]    blk_int34_o,
    output logic      [16*8-1:0]    blk_flt_o
);
    fcw_state_e  state_reg, state_next;
    logic [7:0]  last_cmd_reg, last_cmd_next;
    logic [2:0]  cnt_reg, cnt_next;
    logic [2:0]  idx_reg, idx_next;
    logic [15:0] addr_reg, addr_next;
    logic [15:0] data_reg, data_next;
    logic        wr_reg, wr_next;
    logic [15:0] win_reg, win_next;
    logic        prst_reg, prst_next;
    logic        oth_reg, oth_next;
    logic [7:0]  code_reg, code_next;
    logic [16*8-1:0] words_reg, words_next;
    logic [7:0]  cmd_byte;
    logic [7:0]  cnt_byte;
    logic        fire;

    assign cmd_byte = cmd_area_i[(CMD_AREA_BYTES-CMD_BYTE_IDX)*8-1 -: 8];
    assign cnt_byte = cmd_area_i[(CMD_AREA_BYTES-COUNT_BYTE_IDX)*8-1 -: 8];
    // same code seen again is not re-run; master must zero it first
    assign fire = upd_i && (cmd_byte != last_cmd_reg) && (cmd_byte != CMD_NONE);

    // command decode and register write sequencing
    always_comb
    begin
        state_next    = state_reg;
        last_cmd_next = upd_i ? cmd_byte : last_cmd_reg;
        cnt_next      = cnt_reg;
        idx_next      = idx_reg;
        addr_next     = addr_reg;
        data_next     = data_reg;
        wr_next       = 1'b0;
        win_next      = win_reg;
        prst_next     = 1'b0;
        oth_next      = 1'b0;
        code_next     = code_reg;
        words_next    = words_reg;
        case (state_reg)
            FCW_IDLE:
            begin
                if (fire)
                begin
                    case (cmd_byte)
                        CMD_REG_WRITE:
                        begin
                            // snapshot so later area updates cannot tear the write
                            words_next = cmd_area_i;
                            addr_next  = cmd_area_i[(CMD_AREA_BYTES-ADDR_HI_IDX)*8-1 -: 16];
                            cnt_next   = (cnt_byte > 8'(MAX_WR_WORDS)) ? 3'(MAX_WR_WORDS)
                                                                        : cnt_byte[2:0];
                            idx_next   = '0;
                            if (cnt_byte != 8'h00)
                                state_next = FCW_WRITE;
                        end
                        // count and data bytes are not looked at here
                        CMD_READ_WIN: win_next = cmd_area_i[(CMD_AREA_BYTES-ADDR_HI_IDX)*8-1 -: 16];
                        CMD_CLR_PRST: prst_next = 1'b1;
                        default:
                        begin
                            oth_next  = 1'b1;
                            code_next = cmd_byte;
                        end
                    endcase
                end
            end
            FCW_WRITE:
            begin
                // word idx at bytes 4+2*idx, msb first, to consecutive addresses
                wr_next   = 1'b1;
                data_next = words_reg[(CMD_AREA_BYTES-DATA_FIRST_IDX-2*int'(idx_reg))*8-1 -: 16];
                if (idx_reg != 3'd0)
                    addr_next = addr_reg + 16'h0001;
                idx_next = idx_reg + 3'd1;
                if (idx_reg + 3'd1 == cnt_reg)
                    state_next = FCW_IDLE;
            end
            default: state_next = FCW_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            state_reg    <= FCW_IDLE;
            last_cmd_reg <= CMD_NONE;
            cnt_reg      <= '0;
            idx_reg      <= '0;
            addr_reg     <= '0;
            data_reg     <= '0;
            wr_reg       <= 1'b0;
            win_reg      <= WIN_START_RST;
            prst_reg     <= 1'b0;
            oth_reg      <= 1'b0;
            code_reg     <= CMD_NONE;
            words_reg    <= '0;
        end
        else
        begin
            state_reg    <= state_next;
            last_cmd_reg <= last_cmd_next;
            cnt_reg      <= cnt_next;
            idx_reg      <= idx_next;
            addr_reg     <= addr_next;
            data_reg     <= data_next;
            wr_reg       <= wr_next;
            win_reg      <= win_next;
            prst_reg     <= prst_next;
            oth_reg      <= oth_next;
            code_reg     <= code_next;
            words_reg    <= words_next;
        end
    end

    assign reg_wr_o      = wr_reg;
    assign reg_wr_addr_o = addr_reg;
    assign reg_wr_data_o = data_reg;
    assign win_start_o   = win_reg;
    assign win_len_o     = 5'(READ_WIN_WORDS);
    assign prst_clr_o    = prst_reg;
    assign other_cmd_o   = oth_reg;
    assign other_code_o  = code_reg;
    assign busy_o        = (state_reg != FCW_IDLE);

    // analog output data blocks
    fcw_analog_output_channel_pack fcw_analog_output_channel_pack_i
    (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .ao_int_i    (ao_int_i),
        .ao_dec_i    (ao_dec_i),
        .ao_flt_i    (ao_flt_i),
        .blk_int12_o (blk_int12_o),
        .blk_int34_o (blk_int34_o),
        .blk_flt_o   (blk_flt_o)
    );

    AST_ONCE: assert property (@(posedge mclk_i) disable iff (rst_i)
        upd_i && $past(upd_i) && cmd_byte == $past(cmd_byte) |=> !oth_reg && !prst_reg)
        else $error("repeated command executed twice");
    AST_PRST: assert property (@(posedge mclk_i) disable iff (rst_i)
        state_reg == FCW_IDLE && fire && cmd_byte == CMD_CLR_PRST |=> prst_clr_o)
        else $error("clear-reset command missed");
    AST_WIN: assert property (@(posedge mclk_i) disable iff (rst_i)
        state_reg == FCW_IDLE && fire && cmd_byte == CMD_READ_WIN
        |=> win_start_o == $past(cmd_area_i[111:96]))
        else $error("read window start wrong");
    AST_OTHER: assert property (@(posedge mclk_i) disable iff (rst_i)
        state_reg == FCW_IDLE && fire && cmd_byte < CMD_READ_WIN
        |=> other_cmd_o && other_code_o == $past(cmd_byte))
        else $error("other command not pulsed");
    AST_FIRST: assert property (@(posedge mclk_i) disable iff (rst_i)
        state_reg == FCW_IDLE && fire && cmd_byte == CMD_REG_WRITE && cnt_byte != 8'h00
        |=> ##1 reg_wr_o && reg_wr_addr_o == $past(cmd_area_i[111:96], 2)
            && reg_wr_data_o == $past(cmd_area_i[95:80], 2))
        else $error("first register write wrong");
    AST_SEQ: assert property (@(posedge mclk_i) disable iff (rst_i)
        reg_wr_o && $past(reg_wr_o) |-> reg_wr_addr_o == $past(reg_wr_addr_o) + 16'h0001)
        else $error("write addresses not consecutive");
    AST_NOZERO: assert property (@(posedge mclk_i) disable iff (rst_i)
        upd_i && cmd_byte == CMD_NONE |=> !other_cmd_o && !prst_clr_o)
        else $error("zero command executed");
    AST_LEN: assert property (@(posedge mclk_i) disable iff (rst_i)
        state_reg == FCW_IDLE && fire && cmd_byte == CMD_REG_WRITE && cnt_byte == 8'h01
        |=> ##1 reg_wr_o ##1 !reg_wr_o)
        else $error("write count not honoured");

    // write length, busy coupling, commands refused while busy, and window start hold
    AST_CLIP: assert property (@(posedge mclk_i) disable iff (rst_i)
        state_reg == FCW_IDLE && fire && cmd_byte == CMD_REG_WRITE && cnt_byte > 8'h06
        |=> ##6 reg_wr_o ##1 !reg_wr_o)
        else $error("write count not clipped to six");
    AST_NOCNT: assert property (@(posedge mclk_i) disable iff (rst_i)
        state_reg == FCW_IDLE && fire && cmd_byte == CMD_REG_WRITE && cnt_byte == 8'h00
        |=> !busy_o ##1 !reg_wr_o)
        else $error("zero count wrote a register");
    AST_WRBUSY: assert property (@(posedge mclk_i) disable iff (rst_i)
        reg_wr_o |-> $past(busy_o))
        else $error("register write outside busy phase");
    AST_BUSYIGN: assert property (@(posedge mclk_i) disable iff (rst_i)
        busy_o |=> !other_cmd_o && !prst_clr_o)
        else $error("command executed while busy");
    AST_WINHOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
        !(state_reg == FCW_IDLE && fire && cmd_byte == CMD_READ_WIN)
        |=> $stable(win_start_o))
        else $error("read window start moved without command");
endmodule // fcw_command_window

// [fcw_master.sv]
`timescale 1ns/1ps
// fieldbus master model: writes a command image and marks it with one update pulse
module fcw_master
(
    input  wire logic           mclk_i,
    output logic                upd_o,
    output logic [16*8-1:0]     cmd_area_o
);
    logic [7:0] last_code;
    initial
    begin
        upd_o = 1'b0;
        cmd_area_o = '0;
        last_code = 8'h00;
    end
    // one image refresh; the image stays put between refreshes
    task automatic send_one(input logic [127:0] area, input bit hold);
        @(posedge mclk_i);
        cmd_area_o <= area;
        upd_o <= 1'b1;
        @(posedge mclk_i);
        // a held update marks the same image on two edges in a row
        if (hold)
            @(posedge mclk_i);
        upd_o <= 1'b0;
        last_code = area[127:120];
        repeat (3) @(posedge mclk_i);
    endtask
    // zero the command byte first when repeating a code, unless a repeat is wanted;
    // a wanted repeat also holds the update level for two edges
    task automatic send(input logic [127:0] area, input bit rep);
        if (!rep && area[127:120] == last_code)
        begin
            send_one({8'h00, area[119:0]}, 1'b0);
        end
        send_one(area, rep);
    endtask
endmodule // fcw_master

// [tb_fieldbus_command_window.sv]
`timescale 1ns/1ps
module tb_fieldbus_command_window
    import fcw_pkg::*;
;
    logic           mclk_i, rst_i, upd_i, reg_wr_o, prst_clr_o, other_cmd_o, busy_o;
    logic [127:0]   cmd_area_i, ao_int_i, ao_flt_i, blk_int12_o, blk_int34_o, blk_flt_o;
    logic [63:0]    ao_dec_i;
    logic [15:0]    reg_wr_addr_o, reg_wr_data_o, win_start_o;
    logic [4:0]     win_len_o;
    logic [7:0]     other_code_o, code;
    logic [34:0]    exp_q[$];
    int             fail_count, compares;
    fcw_command_window fcw_command_window_i (.mclk_i, .rst_i, .upd_i, .cmd_area_i, .ao_int_i,
        .ao_dec_i, .ao_flt_i, .reg_wr_o, .reg_wr_addr_o, .reg_wr_data_o, .win_start_o,
        .win_len_o, .prst_clr_o, .other_cmd_o, .other_code_o, .busy_o, .blk_int12_o,
        .blk_int34_o, .blk_flt_o);
    fcw_master fcw_master_i (.mclk_i(mclk_i), .upd_o(upd_i), .cmd_area_o(cmd_area_i));
    // clock
    initial
    begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic conclude();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // monitor: every action pulse takes the oldest note off the queue
    always @(negedge mclk_i)
    begin
        if (!rst_i && (reg_wr_o === 1'b1 || prst_clr_o === 1'b1 || other_cmd_o === 1'b1))
        begin
            if (exp_q.size() == 0)
                chk("unexpected action", 128'h0, 128'h1);
            else
                chk("action", 128'(exp_q.pop_front()), 128'({other_cmd_o, prst_clr_o,
                    reg_wr_o, reg_wr_o ? reg_wr_addr_o : 16'h0000,
                    reg_wr_o ? reg_wr_data_o : (other_cmd_o ? {8'h00, other_code_o} : 16'h0000)}));
        end
    end
    // one command through the master, then wait out the busy phase
    task automatic run(input logic [127:0] area, input bit rep);
        int n;
        fcw_master_i.send(area, rep);
        n = 0;
        @(negedge mclk_i);
        while (busy_o === 1'b1 && n < 20)
        begin
            @(negedge mclk_i);
            n++;
        end
        chk("busy bounded", 128'h0, 128'(n == 20));
    endtask
    // register write; notes the clipped run of consecutive words
    task automatic wr(input logic [7:0] cnt, input logic [15:0] addr, input logic [95:0] d);
        for (int i = 0; i < ((cnt > MAX_WR_WORDS) ? MAX_WR_WORDS : cnt); i++)
            exp_q.push_back({3'b001, addr + 16'(i), d[95-16*i -: 16]});
        run({CMD_REG_WRITE, cnt, addr, d}, 1'b0);
    endtask
    initial
    begin
        #200000;
        fail_count++;
        conclude();
    end
    // main sequence
    initial
    begin
        fail_count = 0;
        compares = 0;
        rst_i = 1'b1;
        ao_int_i = '0;
        ao_dec_i = '0;
        ao_flt_i = '0;
        void'($urandom(40972));
        repeat (20) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(negedge mclk_i);
        chk("win start reset", 128'(WIN_START_RST), 128'(win_start_o));
        wr(8'h02, 16'hB3CA, {32'h42F70000, 64'h0});
        wr(8'h03, 16'hA4B9, {32'h0000303E, 16'h0002, 48'h0});
        wr(8'h06, 16'($urandom), {$urandom, $urandom, $urandom});
        wr(8'h09, 16'hFFFE, {$urandom, $urandom, $urandom});
        wr(8'h00, 16'($urandom), {$urandom, $urandom, $urandom});
        wr(8'h01, 16'($urandom), {$urandom, $urandom, $urandom});
        $display("test register write done");
        run({CMD_READ_WIN, 8'($urandom), 16'hAC2A, $urandom, $urandom, $urandom}, 1'b0);
        chk("win start", 128'h0AC2A, 128'(win_start_o));
        chk("win len", 128'(READ_WIN_WORDS), 128'(win_len_o));
        exp_q.push_back({3'b010, 32'h0});
        run({CMD_CLR_PRST, 8'($urandom), 16'($urandom), $urandom, $urandom, $urandom}, 1'b0);
        $display("test window and clear done");
        repeat (4)
        begin
            code = 8'($urandom_range(1, 249));
            exp_q.push_back({3'b100, 16'h0, 8'h00, code});
            run({code, 8'($urandom), 16'($urandom), 96'($urandom)}, 1'b0);
            run({code, 8'($urandom), 16'($urandom), 96'($urandom)}, 1'b1);
            exp_q.push_back({3'b100, 16'h0, 8'h00, code});
            run({code, 8'($urandom), 16'($urandom), 96'($urandom)}, 1'b0);
            chk("other code", 128'(code), 128'(other_code_o));
        end
        code = 8'hFD + 8'($urandom_range(0, 2));
        exp_q.push_back({3'b100, 16'h0, 8'h00, code});
        run({code, 8'($urandom), 16'($urandom), 96'($urandom)}, 1'b0);
        chk("other code", 128'(code), 128'(other_code_o));
        $display("test other commands done");
        repeat (4)
        begin
            @(posedge mclk_i);
            ao_int_i <= {$urandom, $urandom, $urandom, $urandom};
            ao_dec_i <= {$urandom, $urandom};
            ao_flt_i <= {$urandom, $urandom, $urandom, $urandom};
            repeat (3) @(posedge mclk_i);
            @(negedge mclk_i);
            chk("int block 1-2", {ao_int_i[31:0], ao_dec_i[15:0], 16'h0, ao_int_i[63:32],
                ao_dec_i[31:16], 16'h0}, blk_int12_o);
            chk("int block 3-4", {ao_int_i[95:64], ao_dec_i[47:32], 16'h0, ao_int_i[127:96],
                ao_dec_i[63:48], 16'h0}, blk_int34_o);
            chk("float block", {ao_flt_i[31:0], ao_flt_i[63:32], ao_flt_i[95:64],
                ao_flt_i[127:96]}, blk_flt_o);
        end
        $display("test output blocks done");
        chk("pending actions", 128'h0, 128'(exp_q.size()));
        conclude();
    end
endmodule // tb_fieldbus_command_window
